// >>> logic/bpl_params.svh
// Purpose: Timing, pattern and field constants for the power line modem PHY.
// Assumes: A 40 MHz core clock.
// Notes: Cycle counts derive from times in nanoseconds.
`ifndef BPL_PARAMS_SVH
`define BPL_PARAMS_SVH
`define BPL_CLK_NS 25
`define BPL_TX_TICK_NS 633
`define BPL_TX_TICK_CYC (`BPL_TX_TICK_NS / `BPL_CLK_NS)
`define BPL_SAMP_NS 7299
`define BPL_SAMP_CYC (`BPL_SAMP_NS / `BPL_CLK_NS)
`define BPL_PHASES 12
`define BPL_SQ_HIGH 6
`define BPL_MINUS_DLY 4
`define BPL_CYC_PER_BIT 24
`define BPL_SAMP_PER_BIT 25
`define BPL_IF_SAMPS 8
`define BPL_PRE_LEN 24
`define BPL_PREAMBLE 24'hAA_AAAA
`define BPL_CW_LEN 11
`define BPL_WSYNC 11'h67B
`define BPL_EOP 11'h733
`define BPL_SUFFIX 2'h1
`define BPL_CRC_POLY 16'h1021
`define BPL_CRC_INIT 16'hFFFF
`define BPL_BUSY_RUN 5'h08
`define BPL_WORD_WAIT 6'h23
`endif

// >>> logic/bpl_pkg.sv
// Purpose: Types and the CRC helper shared by the modem PHY.
// Assumes: Constants come from the params header.
// Notes: Gray codes along the main state sequences; the return to idle and the return from data to bit hunt change two bits.
`include "bpl_params.svh"
package bpl_pkg;
	typedef enum logic [1:0] {RX_HUNT_BIT = 2'h0, RX_HUNT_WORD = 2'h1, RX_DATA = 2'h3} bpl_rx_st_t;
	typedef enum logic [2:0] {TX_IDLE = 3'h0, TX_WAIT = 3'h1, TX_PRE = 3'h3, TX_SYNC = 3'h2,
		TX_DATA = 3'h6, TX_CRC = 3'h7, TX_EOP = 3'h5} bpl_tx_st_t;
	typedef struct packed {logic valid; logic last; logic [7:0] data;} bpl_tx_req_t;
	typedef struct packed {
		logic byteValid;
		logic [7:0] data;
		logic parityErr;
		logic frameGood;
		logic frameBad;
	} bpl_rx_evt_t;
	// One byte of CRC-16, most significant bit first.
	function automatic logic [15:0] bpl_crc_byte(input logic [15:0] crc, input logic [7:0] d);
		logic [15:0] c;
		c = crc;
		for (int i = 7; i >= 0; i--) begin
			c = (c[15] ^ d[i]) ? ((c << 1) ^ `BPL_CRC_POLY) : (c << 1);
		end
		return c;
	endfunction : bpl_crc_byte
endpackage : bpl_pkg

// >>> logic/bpl_phy.sv
// Purpose: Digital BPSK power line PHY: tri-level pulse transmitter and sampled receiver.
// Assumes: adcData is stable when adcDone rises; the host holds each byte until txReady.
// Notes: The phase-locked loop is reduced to a fixed local reference correlator.
`timescale 1ns/10ps
`include "bpl_params.svh"
module bpl_phy #(
	parameter int ADC_W = 12,
	parameter int TICK_CYC = `BPL_TX_TICK_CYC,
	parameter int SAMP_CYC = `BPL_SAMP_CYC
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire bpl_pkg::bpl_tx_req_t txReq,
	output logic txReady,
	output logic txActive,
	output logic txPlus,
	output logic txMinus,
	output logic adcStart,
	input wire logic adcDone,
	input wire logic signed [ADC_W-1:0] adcData,
	output bpl_pkg::bpl_rx_evt_t rxEvt
);
	bpl_pkg::bpl_tx_st_t txState_reg;
	bpl_pkg::bpl_rx_st_t rxState_reg;
	logic [8:0] tickCnt_reg;
	logic [3:0] phase_reg;
	logic [4:0] carr_reg;
	logic [23:0] txSh_reg;
	logic [4:0] txLeft_reg;
	logic lastTaken_reg;
	logic crcIdx_reg;
	logic [15:0] txCrc_reg;
	logic [3:0] txPh;
	logic tick;
	logic bitEnd;
	logic chanBusy;

	// Carrier timing runs only within a frame so each frame starts at phase zero.
	assign tick = (tickCnt_reg == 9'(TICK_CYC - 1));
	assign bitEnd = tick && phase_reg == 4'(`BPL_PHASES - 1) && carr_reg == 5'(`BPL_CYC_PER_BIT - 1);
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tickCnt_reg <= 9'h000;
			phase_reg <= 4'h0;
			carr_reg <= 5'h00;
		end else if (!txActive) begin
			tickCnt_reg <= 9'h000;
			phase_reg <= 4'h0;
			carr_reg <= 5'h00;
		end else begin
			tickCnt_reg <= tick ? 9'h000 : tickCnt_reg + 9'h001;
			if (tick) begin
				phase_reg <= (phase_reg == 4'(`BPL_PHASES - 1)) ? 4'h0 : phase_reg + 4'h1;
				if (phase_reg == 4'(`BPL_PHASES - 1)) begin
					carr_reg <= bitEnd ? 5'h00 : carr_reg + 5'h01;
				end
			end
		end
	end

	// A one shifts the whole pattern by half a carrier, which is the 180 degree phase.
	assign txPh = txSh_reg[23] ? ((phase_reg >= 4'(`BPL_SQ_HIGH)) ? phase_reg - 4'(`BPL_SQ_HIGH)
		: phase_reg + 4'(`BPL_SQ_HIGH)) : phase_reg;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			txPlus <= 1'b0;
			txMinus <= 1'b1;
		end else if (!txActive) begin
			txPlus <= 1'b0;
			txMinus <= 1'b1;
		end else begin
			// Both high gives the positive third, both low the negative third.
			txPlus <= (txPh < 4'(`BPL_SQ_HIGH));
			txMinus <= !(txPh >= 4'(`BPL_MINUS_DLY) &&
				txPh < 4'(`BPL_MINUS_DLY + `BPL_SQ_HIGH));
		end
	end

	// Frame sequencer: preamble, word sync, codewords, CRC, end pattern.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			txState_reg <= bpl_pkg::TX_IDLE;
			txActive <= 1'b0;
			txReady <= 1'b0;
			txSh_reg <= 24'h00_0000;
			txLeft_reg <= 5'h00;
			lastTaken_reg <= 1'b0;
			crcIdx_reg <= 1'b0;
			txCrc_reg <= `BPL_CRC_INIT;
		end else begin
			txReady <= 1'b0;
			case (txState_reg)
				bpl_pkg::TX_IDLE: begin
					txActive <= 1'b0;
					if (txReq.valid) begin
						txState_reg <= bpl_pkg::TX_WAIT;
					end
				end
				bpl_pkg::TX_WAIT: begin
					if (!chanBusy) begin
						txState_reg <= bpl_pkg::TX_PRE;
						txActive <= 1'b1;
						txSh_reg <= `BPL_PREAMBLE;
						txLeft_reg <= 5'(`BPL_PRE_LEN);
						txCrc_reg <= `BPL_CRC_INIT;
						lastTaken_reg <= 1'b0;
						crcIdx_reg <= 1'b0;
					end
				end
				default: begin
					if (bitEnd && txLeft_reg > 5'h01) begin
						txSh_reg <= {txSh_reg[22:0], 1'b0};
						txLeft_reg <= txLeft_reg - 5'h01;
					end else if (bitEnd) begin
						txLeft_reg <= 5'(`BPL_CW_LEN);
						if (txState_reg == bpl_pkg::TX_PRE) begin
							txState_reg <= bpl_pkg::TX_SYNC;
							txSh_reg <= {`BPL_WSYNC, 13'h0000};
						end else if (txState_reg == bpl_pkg::TX_EOP) begin
							txState_reg <= bpl_pkg::TX_IDLE;
							txActive <= 1'b0;
						end else if (txState_reg != bpl_pkg::TX_CRC && !lastTaken_reg &&
							txReq.valid) begin
							txState_reg <= bpl_pkg::TX_DATA;
							txSh_reg <= {txReq.data, ^txReq.data, `BPL_SUFFIX, 13'h0000};
							txCrc_reg <= bpl_pkg::bpl_crc_byte(txCrc_reg, txReq.data);
							lastTaken_reg <= txReq.last;
							txReady <= 1'b1;
						end else if (txState_reg != bpl_pkg::TX_CRC) begin
							// A missing byte ends the message, so the CRC still follows.
							txState_reg <= bpl_pkg::TX_CRC;
							crcIdx_reg <= 1'b1;
							txSh_reg <= {txCrc_reg[15:8], ^txCrc_reg[15:8], `BPL_SUFFIX, 13'h0000};
						end else if (crcIdx_reg) begin
							// The low CRC byte keeps the state so the end pattern still follows it.
							crcIdx_reg <= 1'b0;
							txSh_reg <= {txCrc_reg[7:0], ^txCrc_reg[7:0], `BPL_SUFFIX, 13'h0000};
						end else begin
							txState_reg <= bpl_pkg::TX_EOP;
							txSh_reg <= {`BPL_EOP, 13'h0000};
						end
					end
				end
			endcase
		end
	end

	// Conversion start is a free running strobe; no frame activity may disturb it.
	logic [9:0] sampTimer_reg;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sampTimer_reg <= 10'h000;
			adcStart <= 1'b0;
		end else begin
			sampTimer_reg <= (sampTimer_reg == 10'(SAMP_CYC - 1)) ? 10'h000 : sampTimer_reg + 10'h001;
			adcStart <= (sampTimer_reg == 10'(SAMP_CYC - 1));
		end
	end

	// Done pin synchroniser; the level counts only when the second and third stages agree.
	logic doneS1_reg, doneS2_reg, doneS3_reg, doneLvl_reg, sampEvt;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			doneS1_reg <= 1'b0;
			doneS2_reg <= 1'b0;
			doneS3_reg <= 1'b0;
			doneLvl_reg <= 1'b0;
		end else begin
			doneS1_reg <= adcDone;
			doneS2_reg <= doneS1_reg;
			doneS3_reg <= doneS2_reg;
			if (doneS2_reg == doneS3_reg) begin
				doneLvl_reg <= doneS3_reg;
			end
		end
	end
	assign sampEvt = doneS2_reg && doneS3_reg && !doneLvl_reg;

	// Correlate the first 24 samples of each bit with the local reference; the sign gives the bit.
	logic signed [ADC_W+5:0] acc_reg;
	logic [2:0] ifCnt_reg;
	logic [4:0] sampCnt_reg;
	logic bitEvt_reg, rxBit_reg;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_reg <= '0;
			ifCnt_reg <= 3'h0;
			sampCnt_reg <= 5'h00;
			bitEvt_reg <= 1'b0;
			rxBit_reg <= 1'b0;
		end else begin
			bitEvt_reg <= 1'b0;
			if (sampEvt) begin
				ifCnt_reg <= ifCnt_reg + 3'h1;
				if (sampCnt_reg == 5'(`BPL_SAMP_PER_BIT - 1)) begin
					sampCnt_reg <= 5'h00;
					acc_reg <= '0;
					bitEvt_reg <= 1'b1;
					rxBit_reg <= acc_reg[ADC_W+5];
				end else begin
					sampCnt_reg <= sampCnt_reg + 5'h01;
					acc_reg <= (ifCnt_reg < 3'(`BPL_IF_SAMPS / 2)) ? acc_reg + (ADC_W+6)'(adcData)
						: acc_reg - (ADC_W+6)'(adcData);
				end
			end
		end
	end

	// Bit stream hunt: bit sync, then word sync, then codewords.
	logic [23:0] hist_reg;
	logic [10:0] cw_reg;
	logic [5:0] cwCnt_reg;
	logic pol_reg;
	logic [4:0] altRun_reg;
	logic [15:0] rxCrc_reg;
	logic [10:0] cwNext;
	assign cwNext = {cw_reg[9:0], rxBit_reg ^ pol_reg};
	assign chanBusy = (rxState_reg != bpl_pkg::RX_HUNT_BIT) || (altRun_reg >= `BPL_BUSY_RUN);
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxState_reg <= bpl_pkg::RX_HUNT_BIT;
			hist_reg <= 24'h00_0000;
			cw_reg <= 11'h000;
			cwCnt_reg <= 6'h00;
			pol_reg <= 1'b0;
			altRun_reg <= 5'h00;
			rxCrc_reg <= `BPL_CRC_INIT;
			rxEvt <= '0;
		end else begin
			rxEvt <= '0;
			if (bitEvt_reg) begin
				hist_reg <= {hist_reg[22:0], rxBit_reg};
				altRun_reg <= (rxBit_reg != hist_reg[0]) ? ((&altRun_reg) ? altRun_reg
					: altRun_reg + 5'h01) : 5'h00;
				cw_reg <= cwNext;
				case (rxState_reg)
					bpl_pkg::RX_HUNT_BIT: begin
						if ({hist_reg[22:0], rxBit_reg} == `BPL_PREAMBLE ||
							{hist_reg[22:0], rxBit_reg} == ~`BPL_PREAMBLE) begin
							rxState_reg <= bpl_pkg::RX_HUNT_WORD;
							cwCnt_reg <= 6'h00;
						end
					end
					bpl_pkg::RX_HUNT_WORD: begin
						cwCnt_reg <= cwCnt_reg + 6'h01;
						if ({hist_reg[9:0], rxBit_reg} == `BPL_WSYNC ||
							{hist_reg[9:0], rxBit_reg} == ~`BPL_WSYNC) begin
							rxState_reg <= bpl_pkg::RX_DATA;
							// Inverted polarity exactly when the inverse pattern matched.
							pol_reg <= ({hist_reg[9:0], rxBit_reg} != `BPL_WSYNC);
							cwCnt_reg <= 6'h00;
							rxCrc_reg <= `BPL_CRC_INIT;
						end else if (cwCnt_reg == `BPL_WORD_WAIT) begin
							rxState_reg <= bpl_pkg::RX_HUNT_BIT;
						end
					end
					default: begin
						cwCnt_reg <= cwCnt_reg + 6'h01;
						if (cwCnt_reg == 6'(`BPL_CW_LEN - 1)) begin
							cwCnt_reg <= 6'h00;
							if (cwNext == `BPL_EOP) begin
								rxState_reg <= bpl_pkg::RX_HUNT_BIT;
								rxEvt.frameGood <= (rxCrc_reg == 16'h0000);
								rxEvt.frameBad <= (rxCrc_reg != 16'h0000);
							end else if (^cwNext[10:2]) begin
								rxState_reg <= bpl_pkg::RX_HUNT_BIT;
								rxEvt.parityErr <= 1'b1;
								rxEvt.frameBad <= 1'b1;
							end else begin
								rxEvt.byteValid <= 1'b1;
								rxEvt.data <= cwNext[10:3];
								rxCrc_reg <= bpl_pkg::bpl_crc_byte(rxCrc_reg, cwNext[10:3]);
							end
						end
					end
				endcase
			end
		end
	end

	// Checks on the transmit and receive behaviour.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	idle_line_zero_a: assert property (!txActive |=> !txPlus && txMinus)
		else $error("Line drive not neutral while idle.");
	pos_third_a: assert property (txActive && !txSh_reg[23] &&
		phase_reg < 4'(`BPL_MINUS_DLY) |=> txPlus && txMinus)
		else $error("Positive pulse missing in first third.");
	minus_delay_a: assert property (txActive && !txSh_reg[23] &&
		phase_reg == 4'(`BPL_MINUS_DLY) |=> !txMinus)
		else $error("Second output not delayed by four ticks.");
	// The preamble load at frame start is no bit boundary, so the first active cycle is skipped.
	bit_boundary_a: assert property (txActive && $past(txActive) &&
		$changed(txSh_reg) |-> $past(bitEnd))
		else $error("Bit changed away from a bit boundary.");
	carrier_sense_a: assert property (txState_reg == bpl_pkg::TX_WAIT &&
		chanBusy |=> !txActive)
		else $error("Frame started while channel busy.");
	crc_follows_a: assert property (txState_reg == bpl_pkg::TX_DATA && bitEnd && txLeft_reg == 5'h01
		&& lastTaken_reg |=> txState_reg == bpl_pkg::TX_CRC)
		else $error("CRC did not follow last byte.");
	strobe_rate_a: assert property (adcStart |=> !adcStart ##1 !adcStart)
		else $error("Sample strobe not periodic.");
	word_after_bit_a: assert property (rxState_reg == bpl_pkg::RX_HUNT_WORD |-> $past(rxState_reg)
		!= bpl_pkg::RX_DATA)
		else $error("Word sync hunt entered from data.");
	outcome_rehunt_a: assert property (rxEvt.frameGood || rxEvt.frameBad |-> rxState_reg
		== bpl_pkg::RX_HUNT_BIT)
		else $error("Receiver did not return to bit hunt.");
	frame_sent_c: cover property (txState_reg == bpl_pkg::TX_EOP && bitEnd);
	frame_good_c: cover property (rxEvt.frameGood);
	parity_bad_c: cover property (rxEvt.parityErr);
endmodule : bpl_phy

// >>> testbench/bpl_line_model.sv
// Purpose: Behavioural coupling network and converter for the modem PHY bench.
// Assumes: One conversion per adcStart pulse; a line bit spans 25 conversions.
// Notes: The bench queues line bits; an empty queue sends zeros.
`timescale 1ns/10ps
module bpl_line_model #(
	parameter int ADC_W = 12,
	parameter int AMP = 600
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic adcStart,
	output logic adcDone,
	output logic signed [ADC_W-1:0] adcData
);
	localparam logic signed [ADC_W-1:0] AMP_S = AMP;
	logic bitQueue[$];
	int sampCnt;
	int hiCnt;
	logic curBit;
	// Queues one bit; zeros never alternate, so an idle line never looks busy.
	function automatic void push(input logic b);
		bitQueue.push_back(b);
	endfunction : push
	// Each start gives a five-cycle done pulse whose sample sign carries the bit phase.
	// Once done falls the bus shows the inverse, so a late capture cannot pass.
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			adcDone <= 1'b0;
			adcData <= '0;
			sampCnt = 0;
			hiCnt = 0;
			curBit = 1'b0;
		end else if (adcStart) begin
			if (sampCnt % 25 == 0) curBit = (bitQueue.size() > 0) ? bitQueue.pop_front() : 1'b0;
			adcData <= (((sampCnt % 8) < 4) ^ curBit) ? AMP_S : -AMP_S;
			adcDone <= 1'b1;
			hiCnt = 5;
			sampCnt++;
		end else if (hiCnt > 0) begin
			hiCnt--;
			if (hiCnt == 0) begin
				adcDone <= 1'b0;
				adcData <= ~adcData;
			end
		end
	end
endmodule : bpl_line_model

// >>> testbench/bpsk_powerline_phy_bench.sv
// Purpose: Self-checking bench for the BPSK power line PHY.
// Assumes: Short counts of two clocks per tick and ten clocks per sample.
// Notes: Transmit bits are read back from the two pulse outputs.
`timescale 1ns/10ps
module bpsk_powerline_phy_bench;
	localparam int TICK = 2;
	localparam int SAMP = 10;
	localparam int BIT_CYC = 24 * 12 * TICK;
	localparam logic [7:0] TX_BYTE = 8'hC3;
	logic core_clk;
	logic arst_n;
	bpl_pkg::bpl_tx_req_t txReq;
	logic txReady, txActive, txPlus, txMinus, adcStart, adcDone;
	logic signed [11:0] adcData;
	bpl_pkg::bpl_rx_evt_t rxEvt;
	int nErrors = 0;
	int checksDone = 0;
	int cyc = 0;
	int lastStart = 0;
	logic readySeen = 1'b0;
	bpl_phy #(.ADC_W(12), .TICK_CYC(TICK), .SAMP_CYC(SAMP)) DUT (.core_clk(core_clk),
		.arst_n(arst_n), .txReq(txReq), .txReady(txReady), .txActive(txActive),
		.txPlus(txPlus), .txMinus(txMinus), .adcStart(adcStart), .adcDone(adcDone),
		.adcData(adcData), .rxEvt(rxEvt));
	bpl_line_model #(.ADC_W(12)) LINE (.core_clk(core_clk), .arst_n(arst_n),
		.adcStart(adcStart), .adcDone(adcDone), .adcData(adcData));
	// A 40 MHz clock.
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// Cycle count used to place every transmit sample.
	always @(posedge core_clk) cyc++;
	// Releases the host byte once taken and watches the sampling period.
	always @(posedge core_clk) begin
		#2;
		if (txReady === 1'b1) begin
			readySeen = 1'b1;
			txReq = '0;
		end
		if (adcStart === 1'b1) begin
			if (lastStart > 0) check("adcStartGap", cyc - lastStart, SAMP);
			lastStart = cyc;
		end
	end
	// A hang counts as a mismatch; a clean run ends just under 100000 cycles.
	initial begin
		repeat (110000) @(posedge core_clk);
		nErrors++;
		stop_test();
	end
	task automatic step;
		@(posedge core_clk);
		#2;
	endtask : step
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			nErrors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic stop_test;
		if (nErrors == 0 && checksDone > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test
	function automatic logic [15:0] crc16(input logic [7:0] d);
		logic [15:0] c;
		c = 16'hFFFF;
		for (int i = 7; i >= 0; i--) c = (c[15] ^ d[i]) ? ((c << 1) ^ 16'h1021) : (c << 1);
		return c;
	endfunction : crc16
	// Whole frame, first bit at the top; a bad parity flips the first byte's parity only.
	function automatic logic [78:0] frame_bits(input logic [7:0] d, input logic [15:0] c,
		input logic badPar);
		return {24'hAA_AAAA, 11'h67B, d, (^d) ^ badPar, 2'h1, c[15:8], ^c[15:8], 2'h1,
			c[7:0], ^c[7:0], 2'h1, 11'h733};
	endfunction : frame_bits
	// Sends one frame into the receiver and judges its events; may queue a frame to send.
	task automatic rx_frame(input logic [7:0] d, input logic inv, input logic [15:0] crcXor,
		input logic badPar, input logic deferTx, input logic [2:0] expEnd);
		logic [78:0] f;
		logic [7:0] firstByte;
		logic [2:0] got;
		logic gotByte;
		logic sawActive;
		f = frame_bits(d, crc16(d) ^ crcXor, badPar);
		for (int k = 78; k > (badPar ? 32 : -1); k--) LINE.push(f[k] ^ inv);
		for (int k = 0; k < 8; k++) LINE.push(1'b0);
		got = '0;
		gotByte = 1'b0;
		sawActive = 1'b0;
		firstByte = '0;
		for (int k = 0; k < 24000 && got == 3'h0; k++) begin
			step();
			if (deferTx && k == 3500) txReq = '{valid: 1'b1, last: 1'b1, data: TX_BYTE};
			if (txActive !== 1'b0) sawActive = 1'b1;
			if (rxEvt.byteValid === 1'b1 && !gotByte) begin
				gotByte = 1'b1;
				firstByte = rxEvt.data;
			end
			if (rxEvt.frameGood === 1'b1 || rxEvt.frameBad === 1'b1) begin
				got = {rxEvt.parityErr, rxEvt.frameGood, rxEvt.frameBad};
			end
		end
		check("rxEnd", got, expEnd);
		if (!badPar) check("rxByte", firstByte, d);
		if (deferTx) check("txDeferred", sawActive, 1'b0);
	endtask : rx_frame
	// Reads the pending frame back from the pulse outputs, bit by bit.
	task automatic tx_frame(input logic [7:0] d);
		logic [78:0] f;
		logic [23:0] pw;
		logic [23:0] mw;
		logic [1:0] p2;
		int base;
		f = frame_bits(d, crc16(d), 1'b0);
		for (int k = 0; k < 3000 && txPlus !== 1'b1; k++) step();
		base = cyc - 6 * TICK;
		check("txActive", txActive, 1'b1);
		while (cyc < base + 12 * TICK) step();
		for (int k = 0; k < 12 * TICK; k++) begin
			pw[k] = txPlus;
			mw[k] = txMinus;
			step();
		end
		check("plusWave", pw, 24'hFF_F000);
		check("minusWave", mw, 24'h0F_FF00);
		for (int k = 0; k < 79; k++) begin
			while (cyc < base + k * BIT_CYC + 293) step();
			p2 = {txPlus, txMinus};
			while (cyc < base + k * BIT_CYC + 305) step();
			check("txBit", {p2, txPlus, txMinus}, f[78-k] ? 4'h3 : 4'hC);
		end
		while (cyc < base + 79 * BIT_CYC + 40) step();
		check("txIdleEnd", {txActive, txPlus, txMinus, readySeen}, 4'h3);
	endtask : tx_frame
	// Reset, then receive with a deferred send, send, and two faulty receptions.
	initial begin
		arst_n = 1'b0;
		txReq = '0;
		repeat (5) @(posedge core_clk);
		#2;
		check("resetOut", {txActive, txPlus, txMinus, txReady, adcStart, rxEvt}, 17'h0_4000);
		repeat (5) @(posedge core_clk);
		#2;
		arst_n = 1'b1;
		rx_frame(8'hA5, 1'b0, 16'h0000, 1'b0, 1'b1, 3'h2);
		tx_frame(TX_BYTE);
		rx_frame(8'h3C, 1'b0, 16'h0000, 1'b1, 1'b0, 3'h5);
		rx_frame(8'h96, 1'b1, 16'h0001, 1'b0, 1'b0, 3'h1);
		stop_test();
	end
endmodule : bpsk_powerline_phy_bench
